// *** rtc_defs.svh ***
// Purpose: offsets, field layouts and timing counts of the time-of-day block
// Assumes: byte-wide registers at their printed addresses, 10 MHz core clock
// Notes:   definitions only, included by bare name
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// register addresses
`define RTC_ADDR_W 12
`define RTC_SECOND_ADDR 12'h320
`define RTC_MINUTE_ADDR 12'h321
`define RTC_HOUR_ADDR 12'h322
`define RTC_FORMAT_ADDR 12'h325
`define RTC_PAGE_ADDR 12'h327

// field layouts
`define RTC_PAGE_BIT 0
`define RTC_FORMAT_BIT 0
`define RTC_PM_BIT 5
`define RTC_SEC_MASK 8'h7F
`define RTC_MIN_MASK 8'h7F
`define RTC_HOUR_MASK 8'h3F

// wrap points in packed bcd
`define RTC_SEC_MAX 7'h59
`define RTC_MIN_MAX 7'h59
`define RTC_HOUR24_MAX 7'h23
`define RTC_HOUR12_MAX 7'h11

// reset values of control state
`define RTC_PAGE_RST 1'b0
`define RTC_RDATA_RST 8'h00

// timing: one second of timebase at the core clock rate
`define RTC_CLK_PERIOD_NS 100
`define RTC_SECOND_NS 1000000000
`define RTC_SECOND_CYCLES (`RTC_SECOND_NS / `RTC_CLK_PERIOD_NS)

`endif

// *** rtc_pkg.sv ***
// Purpose: shared types of the time-of-day block
// Assumes: offsets and counts live in rtc_defs.svh
// Notes:   nothing here is imported; users write rtc_pkg::name
package rtc_pkg;

  // register page currently selected by software
  typedef enum logic [1:0] {
    RTC_TIME_PAGE  = 2'b01,
    RTC_ALARM_PAGE = 2'b10
  } rtc_page_e;

  // one set of time-of-day fields, packed bcd
  typedef struct packed {
    logic [6:0] second_count;
    logic [6:0] minute_count;
    logic [5:0] hour_count;
  } rtc_time_s;

endpackage

// *** rtc_bcd_step.sv ***
// Purpose: one packed-bcd digit pair advanced by one with a wrap point
// Assumes: input is a valid bcd value not above the wrap point
// Notes:   purely combinational; the caller decides when to take the result
`timescale 1ns/10ps
module rtc_bcd_step (
  input wire logic [6:0] value_in, // current bcd value
  input wire logic [6:0] max_in, // last value before wrapping to zero
  output logic [6:0] next_out, // value plus one, or zero on wrap
  output logic wrap_out // high when the value wraps to zero
);

  // bcd increment: units roll 9 to 0 and carry into tens
  function automatic logic [6:0] bcd_inc(input logic [6:0] v);
    logic [6:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {3'(v[6:4] + 3'h1), 4'h0};
    end else begin
      r = {v[6:4], 4'(v[3:0] + 4'h1)};
    end
    return r;
  endfunction

  // wrap check is an exact match, so a value above the wrap point walks further
  always_comb begin
    wrap_out = (value_in == max_in);
    next_out = wrap_out ? 7'h00 : bcd_inc(value_in);
  end

endmodule

// *** rtc_tod.sv ***
// Purpose: time-of-day counting registers of a real-time clock
// Assumes: one 10 MHz clock; byte register port with read data a cycle later
// Notes:   time and alarm fields are kept through system reset
//
// Functional notes
// - time, alarm and format fields are never cleared by system reset.
// - minutes are 7-bit packed bcd 0 to 59 on both pages, bit 7 reads 0.
// - the hour register has bits 7:6 at zero and the hour in bits 5:0.
// - with the format bit at 1 the hour is packed bcd 0 to 23.
// - with the format bit at 0 bit 5 is the pm flag and 4:0 hold 0 to 11.
// - page 0 reads the live count, page 1 reads the alarm fields.
`timescale 1ns/10ps
`include "rtc_defs.svh"
module rtc_tod #(
  parameter int SECOND_CYCLES = `RTC_SECOND_CYCLES // core cycles per second
) (
  input wire logic core_clk_in, // 10 MHz core clock
  input wire logic rstn_in, // asynchronous system reset, active low
  input wire logic [`RTC_ADDR_W-1:0] addr_in, // register byte address
  input wire logic [7:0] wdata_in, // write data
  input wire logic wr_in, // write strobe, one cycle
  input wire logic rd_in, // read strobe, one cycle
  output logic [7:0] rdata_out, // read data, valid the cycle after rd_in
  output logic second_tick_out // one-cycle pulse when a second elapses
);

  // page and format state
  rtc_pkg::rtc_page_e page_reg;
  logic hour_format_bit_reg;

  // live count and alarm copies
  rtc_pkg::rtc_time_s time_reg;
  logic [6:0] alarm_minute_reg;
  logic [5:0] alarm_hour_reg;

  // timebase divider
  logic [31:0] div_reg;
  logic tick;

  // carry chain results
  logic [6:0] sec_next;
  logic [6:0] min_next;
  logic [6:0] hour_next;
  logic [6:0] hour_digits;
  logic [6:0] hour_max;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;

  // write decode
  logic wr_sec;
  logic wr_min;
  logic wr_hour;
  logic wr_alarm_min;
  logic wr_alarm_hour;
  logic wr_format;
  logic wr_page;
  logic on_time_page;

  // read mux
  logic [7:0] rd_value;

  // time page is the only page with a live view
  assign on_time_page = (page_reg == rpkg_time_page());

  function automatic rtc_pkg::rtc_page_e rpkg_time_page();
    return rtc_pkg::RTC_TIME_PAGE;
  endfunction

  // address match shared by every decode term
  function automatic logic hit(input logic [`RTC_ADDR_W-1:0] a,
                               input logic [`RTC_ADDR_W-1:0] want);
    return (a == want);
  endfunction

  // page 0 writes land in the live count, page 1 writes in the alarm copy
  always_comb begin
    wr_sec = wr_in && hit(addr_in, `RTC_SECOND_ADDR) && on_time_page;
    wr_min = wr_in && hit(addr_in, `RTC_MINUTE_ADDR) && on_time_page;
    wr_hour = wr_in && hit(addr_in, `RTC_HOUR_ADDR) && on_time_page;
    wr_alarm_min = wr_in && hit(addr_in, `RTC_MINUTE_ADDR) && !on_time_page;
    wr_alarm_hour = wr_in && hit(addr_in, `RTC_HOUR_ADDR) && !on_time_page;
    wr_format = wr_in && hit(addr_in, `RTC_FORMAT_ADDR) && !on_time_page;
    wr_page = wr_in && hit(addr_in, `RTC_PAGE_ADDR);
  end

  // divider is reset so the tick spacing is defined; the reset only
  // shifts the phase of the next second, it never touches the count
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_reg <= 32'h0000_0000;
      second_tick_out <= 1'b0;
    end else begin
      second_tick_out <= tick;
      if (tick) begin
        div_reg <= 32'h0000_0000;
      end else begin
        div_reg <= div_reg + 32'h0000_0001;
      end
    end
  end

  assign tick = (div_reg == 32'(SECOND_CYCLES - 1));

  // page select is control state and so takes a defined value at reset
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      page_reg <= rtc_pkg::RTC_TIME_PAGE;
    end else if (wr_page) begin
      page_reg <= wdata_in[`RTC_PAGE_BIT] ? rtc_pkg::RTC_ALARM_PAGE
                                          : rtc_pkg::RTC_TIME_PAGE;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (wr_format) begin
      hour_format_bit_reg <= wdata_in[`RTC_FORMAT_BIT];
    end
  end

  rtc_bcd_step u_sec_step (
    .value_in(time_reg.second_count),
    .max_in(`RTC_SEC_MAX),
    .next_out(sec_next),
    .wrap_out(sec_wrap)
  );

  rtc_bcd_step u_min_step (
    .value_in(time_reg.minute_count),
    .max_in(`RTC_MIN_MAX),
    .next_out(min_next),
    .wrap_out(min_wrap)
  );

  // 12-hour leaves the pm flag out of the digits
  always_comb begin
    if (hour_format_bit_reg) begin
      hour_digits = {1'b0, time_reg.hour_count};
      hour_max = `RTC_HOUR24_MAX;
    end else begin
      hour_digits = {2'b00, time_reg.hour_count[4:0]};
      hour_max = `RTC_HOUR12_MAX;
    end
  end

  rtc_bcd_step u_hour_step (
    .value_in(hour_digits),
    .max_in(hour_max),
    .next_out(hour_next),
    .wrap_out(hour_wrap)
  );

  // live count has no reset
  // a write to a field wins over the tick for that field only; the
  // other fields still carry, so a write never costs a second elsewhere
  always_ff @(posedge core_clk_in) begin
    if (wr_sec) begin
      time_reg.second_count <= wdata_in[6:0];
    end else if (tick) begin
      time_reg.second_count <= sec_next;
    end
    // one process owns the whole count so the struct has a single writer
    if (wr_min) begin
      time_reg.minute_count <= wdata_in[6:0];
    end else if (tick && sec_wrap) begin
      time_reg.minute_count <= min_next;
    end
    if (wr_hour) begin
      time_reg.hour_count <= wdata_in[5:0];
    end else if (tick && sec_wrap && min_wrap) begin
      if (hour_format_bit_reg) begin
        time_reg.hour_count <= hour_next[5:0];
      end else begin
        time_reg.hour_count <= {time_reg.hour_count[`RTC_PM_BIT] ^ hour_wrap,
                                hour_next[4:0]};
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (wr_alarm_min) begin
      alarm_minute_reg <= wdata_in[6:0];
    end
    if (wr_alarm_hour) begin
      alarm_hour_reg <= wdata_in[5:0];
    end
  end

  // page steers the read view
  // unused high bits and unmapped addresses read as zero
  always_comb begin
    rd_value = 8'h00;
    case (addr_in)
      `RTC_SECOND_ADDR: begin
        if (on_time_page) begin
          rd_value = {1'b0, time_reg.second_count} & `RTC_SEC_MASK;
        end
      end
      `RTC_MINUTE_ADDR: begin
        rd_value = on_time_page ? {1'b0, time_reg.minute_count}
                                : {1'b0, alarm_minute_reg};
        rd_value = rd_value & `RTC_MIN_MASK;
      end
      `RTC_HOUR_ADDR: begin
        rd_value = on_time_page ? {2'b00, time_reg.hour_count}
                                : {2'b00, alarm_hour_reg};
        rd_value = rd_value & `RTC_HOUR_MASK;
      end
      `RTC_FORMAT_ADDR: begin
        if (!on_time_page) begin
          rd_value = {7'h00, hour_format_bit_reg};
        end
      end
      `RTC_PAGE_ADDR: begin
        rd_value = {7'h00, !on_time_page};
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= `RTC_RDATA_RST;
    end else if (rd_in) begin
      rdata_out <= rd_value;
    end else begin
      rdata_out <= `RTC_RDATA_RST;
    end
  end

endmodule

// *** rtc_tod_sva.sv ***
// Purpose: port checks of the time-of-day block
// Assumes: page select is tracked from writes to 0x327
// Notes: bound from the test top
`timescale 1ns/10ps
module rtc_tod_sva #(
  parameter int SECOND_CYCLES = 10000000 // core cycles per second
) (
  input wire logic core_clk_in, // core clock
  input wire logic rstn_in, // reset, active low
  input wire logic [11:0] addr_in, // address
  input wire logic [7:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  input wire logic [7:0] rdata_out, // read data
  input wire logic second_tick_out // second pulse
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  int cnt;
  logic seen;
  logic page;
  // shadow divider and page; both are cleared by reset like the block
  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 0;
      seen <= 1'b0;
      page <= 1'b0;
    end else begin
      cnt <= (cnt == SECOND_CYCLES - 1) ? 0 : cnt + 1;
      if (cnt == SECOND_CYCLES - 1) seen <= 1'b1;
      if (wr_in && addr_in == 12'h327) page <= wdata_in[0];
    end
  end
  // reads split by the page that was selected
  sequence s_rd(a);
    rd_in && addr_in == a;
  endsequence
  sequence s_rd0(a);
    !page && rd_in && addr_in == a;
  endsequence
  sequence s_rd1(a);
    page && rd_in && addr_in == a;
  endsequence
  chk_rd_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not idle");
  chk_sec_bcd: assert property (s_rd0(12'h320) |=>
    !rdata_out[7] && rdata_out[3:0] <= 4'h9 && rdata_out[6:4] <= 3'h5)
    else $error("seconds field out of range");
  chk_min_top: assert property (s_rd(12'h321) |=>
    !rdata_out[7] && rdata_out[3:0] <= 4'h9)
    else $error("minute field bad");
  chk_hour_top: assert property (s_rd(12'h322) |=>
    rdata_out[7:6] == 2'b00)
    else $error("hour top bits set");
  chk_alarm_sec: assert property (s_rd1(12'h320) |=> rdata_out == 8'h00)
    else $error("seconds visible on alarm page");
  chk_page_read: assert property (s_rd(12'h327) |=>
    rdata_out == {7'h00, page})
    else $error("page select readback wrong");
  chk_tick_when: assert property (second_tick_out |-> seen && cnt == 0)
    else $error("second pulse off schedule");
  chk_tick_due: assert property (seen && cnt == 0 |-> second_tick_out)
    else $error("second pulse missing");
endmodule

// *** rtc_tod_test.sv ***
// Purpose: directed test of the time-of-day block
// Assumes: one second shortened to SEC core cycles
// Notes: steps wait for a tick so no write meets a count advance
`timescale 1ns/10ps
module rtc_tod_test;
  localparam int SEC = 40;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, tick;
  logic [11:0] addr = 12'h000;
  logic [7:0] wd = 8'h00, rdata, d;
  int n_errors = 0, num_checks = 0;
  // 10 MHz core clock
  always #50 clk = ~clk;
  rtc_tod #(.SECOND_CYCLES(SEC)) rtc_tod_i (.core_clk_in(clk),
    .rstn_in(rstn), .addr_in(addr), .wdata_in(wd), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .second_tick_out(tick));
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // a free edge follows each strobe so the next task may raise it again
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] v);
    wr <= 1'b1;
    addr <= a;
    wd <= v;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    num_checks++;
    if (d !== e) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, d, e);
    end
    @(posedge clk);
  endtask
  task automatic num_chk(input int g, input int e);
    num_checks++;
    if (g != e) begin
      n_errors++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // core cycles between two second pulses
  task automatic t_tick();
    int n;
    n = 0;
    for (int i = 0; i < 2 * SEC && tick !== 1'b1; i++) @(posedge clk);
    @(posedge clk);
    n = 1;
    while (tick !== 1'b1 && n < 2 * SEC) begin
      @(posedge clk);
      n++;
    end
    num_chk(n, SEC);
  endtask
  // return just after a count advance, leaving a whole second free
  task automatic sync();
    for (int i = 0; i < 2 * SEC; i++) begin
      @(posedge clk);
      if (tick === 1'b1) break;
    end
    @(posedge clk);
  endtask
  task automatic fmt(input logic [7:0] f);
    wr_reg(12'h327, 8'h01);
    wr_reg(12'h325, f);
    wr_reg(12'h327, 8'h00);
  endtask
  task automatic set(input logic [7:0] s, m, h);
    sync();
    wr_reg(12'h320, s);
    wr_reg(12'h321, m);
    wr_reg(12'h322, h);
  endtask
  task automatic roll(input logic [7:0] f, m, h, me, he);
    fmt(f);
    set(8'h59, m, h);
    sync();
    rd_chk(12'h320, 8'h00);
    rd_chk(12'h321, me);
    rd_chk(12'h322, he);
  endtask
  task automatic t_alarm();
    sync();
    wr_reg(12'h327, 8'h01);
    rd_chk(12'h327, 8'h01);
    wr_reg(12'h321, 8'h30);
    wr_reg(12'h322, 8'h07);
    // seconds exist on the time page only: this write must be lost
    wr_reg(12'h320, 8'h33);
    rd_chk(12'h321, 8'h30);
    rd_chk(12'h322, 8'h07);
    rd_chk(12'h320, 8'h00);
    rd_chk(12'h325, 8'h01);
    wr_reg(12'h327, 8'h00);
    rd_chk(12'h327, 8'h00);
    rd_chk(12'h320, 8'h00);
    rd_chk(12'h321, 8'h46);
    rd_chk(12'h325, 8'h00);
    rd_chk(12'h330, 8'h00);
  endtask
  task automatic t_keep();
    // switch to 24-hour first so the kept format differs from the last roll
    fmt(8'h01);
    set(8'h12, 8'h34, 8'h05);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(12'h320, 8'h12);
    rd_chk(12'h321, 8'h34);
    rd_chk(12'h322, 8'h05);
    wr_reg(12'h327, 8'h01);
    rd_chk(12'h325, 8'h01);
    wr_reg(12'h327, 8'h00);
  endtask
  task automatic t_fields();
    fmt(8'h01);
    // bit 7 set on purpose: it must read back as zero
    set(8'hD9, 8'hC5, 8'hD3);
    rd_chk(12'h320, 8'h59);
    rd_chk(12'h321, 8'h45);
    rd_chk(12'h322, 8'h13);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_fields();
    t_alarm();
    roll(8'h01, 8'h59, 8'h23, 8'h00, 8'h00);
    roll(8'h01, 8'h59, 8'h19, 8'h00, 8'h20);
    roll(8'h01, 8'h29, 8'h09, 8'h30, 8'h09);
    roll(8'h00, 8'h59, 8'h11, 8'h00, 8'h20);
    roll(8'h00, 8'h59, 8'h31, 8'h00, 8'h00);
    roll(8'h00, 8'h59, 8'h29, 8'h00, 8'h30);
    t_tick();
    t_keep();
    report_and_stop();
  end
  // the run needs some twenty seconds of SEC cycles; five times that
  initial begin
    #(100 * SEC * 100);
    n_errors++;
    report_and_stop();
  end
endmodule
bind rtc_tod rtc_tod_sva #(.SECOND_CYCLES(SECOND_CYCLES)) rtc_tod_sva_i (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .second_tick_out(second_tick_out));
